// file: bcd_core.sv
// Purpose: presettable BCD decade counter stage
// Assumes: step pulses mark counting edges; controls stable at aclk edges
// Notes:   ASYNC_CLEAR picks which single clear the stage obeys
`include "bcd_counter_params.svh"

module bcd_core
#(
  parameter bit ASYNC_CLEAR = 1'b1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  count_if.core    ctl
);

  bcd_counter_pkg::bcd_t count_reg;
  bcd_counter_pkg::bcd_t next_count;
  bcd_counter_pkg::bcd_t incremented;
  wire                   async_hit;
  wire                   sync_hit;
  wire                   count_enable;
  wire                   is_nine;

  assign async_hit = ASYNC_CLEAR && !ctl.clear_n;
  assign sync_hit  = !ASYNC_CLEAR && !ctl.clear_n;

  assign count_enable = ctl.parallel_count_enable
                      & ctl.trickle_count_enable
                      & ctl.load_enable_n;

  assign ctl.mode = async_hit     ? bcd_counter_pkg::MODE_CLEAR :
                    sync_hit      ? bcd_counter_pkg::MODE_CLEAR :
                    !ctl.load_enable_n ? bcd_counter_pkg::MODE_LOAD :
                    count_enable  ? bcd_counter_pkg::MODE_COUNT :
                                    bcd_counter_pkg::MODE_HOLD;

  assign incremented = (count_reg == `BCD_LAST)  ? `BCD_FIRST :
                       (count_reg > `BCD_LAST)   ? {1'b0, count_reg[2:0]} :
                                                   count_reg + 4'h1;

  always_comb
  begin
    next_count = count_reg;
    case (ctl.mode)
      bcd_counter_pkg::MODE_CLEAR: next_count = `BCD_FIRST;
      bcd_counter_pkg::MODE_LOAD:  next_count = ctl.preset;
      bcd_counter_pkg::MODE_COUNT: next_count = incremented;
      bcd_counter_pkg::MODE_HOLD:  next_count = count_reg;
      default:                     next_count = count_reg;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= `BCD_FIRST;
    else if (async_hit || ctl.step)
      count_reg <= next_count;
  end

  // async clear forces outputs low at once
  assign ctl.count = async_hit ? `BCD_FIRST : count_reg;

  assign is_nine = (ctl.count == `BCD_NINE_PATTERN);

  assign ctl.terminal_count_out = is_nine & ctl.trickle_count_enable;

endmodule

// file: bcd_counter_params.svh
// Purpose: offsets, field positions, reset values of the decade counter
// Assumes: 5-bit byte address, one 32-bit word per register
// Notes:   definitions only
`ifndef BCD_COUNTER_PARAMS_SVH
`define BCD_COUNTER_PARAMS_SVH

`define CTRL_OFFSET       5'h00
`define PRESET_OFFSET     5'h04
`define STATUS_OFFSET     5'h08
`define STEP_OFFSET       5'h0c

`define CTRL_CLEAR_BIT    0
`define CTRL_LOAD_BIT     1
`define CTRL_PCE_BIT      2
`define CTRL_TCE_BIT      3
`define CTRL_RESET        4'h3
`define PRESET_RESET      4'h0

`define STATUS_TC_BIT     4
`define STATUS_ASYNC_BIT  5
`define STATUS_MODE_LSB   6
`define STEP_BIT          0

`define BCD_FIRST         4'h0
`define BCD_LAST          4'h9
`define BCD_NINE_PATTERN  4'b1001

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// file: bcd_counter_pkg.sv
// Purpose: shared types of the decade counter
// Assumes: nothing
// Notes:   constants live in bcd_counter_params.svh
package bcd_counter_pkg;

  typedef logic [3:0] bcd_t;

  typedef enum logic [1:0]
  {
    MODE_CLEAR = 2'b00,
    MODE_LOAD  = 2'b01,
    MODE_COUNT = 2'b10,
    MODE_HOLD  = 2'b11
  } mode_t;

endpackage

// file: bcd_decade_counter.sv
// Purpose: BCD decade counter with AXI4-Lite control and status
// Assumes: count_clock is synchronous to aclk; one access of each kind
// Notes:   counting edges come from count_clock rises or a step write
//          map: ctrl 0x00, preset 0x04, status 0x08, step 0x0c
//          ctrl bits: 0 clear_n, 1 load_enable_n, 2 parallel, 3 trickle
//          status bits: 3:0 count, 4 terminal, 5 async variant, 7:6 mode
//          status mode is what the next counting edge applies
//          unmapped words answer with a slave error
`include "bcd_counter_params.svh"

module bcd_decade_counter
#(
  parameter bit ASYNC_CLEAR = 1'b1
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output wire logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output wire logic        arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        count_clock,
  input  wire logic        cascade_parallel_enable,
  input  wire logic        cascade_trickle_enable,
  output wire logic [3:0]  count_out,
  output wire logic        terminal_count_out
);

  count_if ctl ();

  logic [3:0]  ctrl;
  logic [3:0]  preset;
  logic        count_clock_q;
  logic        sw_step;
  logic        aw_held;
  logic [4:0]  aw_addr_q;
  logic        w_held;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire         aw_take;
  wire         w_take;
  wire         aw_have;
  wire         w_have;
  wire         wr_fire;
  wire [4:0]   wr_addr;
  wire [4:0]   wr_word;
  wire [31:0]  wr_data;
  wire [3:0]   wr_strb;
  wire         wr_lane0;
  wire         wr_ctrl_sel;
  wire         wr_preset_sel;
  wire         wr_status_sel;
  wire         wr_step_sel;
  wire         wr_mapped;
  wire         rd_fire;
  wire [4:0]   rd_word;
  wire         rd_ctrl_sel;
  wire         rd_preset_sel;
  wire         rd_status_sel;
  wire         rd_step_sel;
  wire         rd_mapped;
  wire [31:0]  status_word;
  wire [31:0]  rd_value;
  wire         pin_rise;
  wire         ctrl_we;
  wire         preset_we;
  wire         step_we;
  wire [1:0]   wr_resp;
  wire [1:0]   rd_resp;
  wire [31:0]  ctrl_word;
  wire [31:0]  preset_word;

  // write channels, address and data accepted in either order
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign aw_have = aw_held || aw_take;
  assign w_have  = w_held || w_take;
  assign wr_fire = aw_have && w_have && !bvalid;

  assign wr_addr = aw_held ? aw_addr_q : awaddr;
  assign wr_data = w_held ? w_data_q : wdata;
  assign wr_strb = w_held ? w_strb_q : wstrb;

  // sub-word address bits ignored, every register is one aligned word
  assign wr_word       = {wr_addr[4:2], 2'b00};
  assign wr_lane0      = wr_strb[0];
  assign wr_ctrl_sel   = (wr_word == `CTRL_OFFSET);
  assign wr_preset_sel = (wr_word == `PRESET_OFFSET);
  assign wr_status_sel = (wr_word == `STATUS_OFFSET);
  assign wr_step_sel   = (wr_word == `STEP_OFFSET);
  assign wr_mapped     = wr_ctrl_sel | wr_preset_sel
                       | wr_status_sel | wr_step_sel;

  // register strobes; every field sits in byte lane 0
  assign ctrl_we   = wr_fire && wr_ctrl_sel && wr_lane0;
  assign preset_we = wr_fire && wr_preset_sel && wr_lane0;
  assign step_we   = wr_fire && wr_step_sel && wr_lane0;
  // status writes are accepted and dropped, only holes give an error
  assign wr_resp   = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;

  // address held until its data partner arrives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_held <= 1'b0;
    else if (wr_fire)
      aw_held <= 1'b0;
    else if (aw_take)
      aw_held <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_addr_q <= 5'h00;
    else if (aw_take)
      aw_addr_q <= awaddr;
  end

  // data held until its address partner arrives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_held <= 1'b0;
    else if (wr_fire)
      w_held <= 1'b0;
    else if (w_take)
      w_held <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_data_q <= 32'h0000_0000;
    else if (w_take)
      w_data_q <= wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_strb_q <= 4'h0;
    else if (w_take)
      w_strb_q <= wstrb;
  end

  // response stands until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bvalid <= 1'b0;
    else if (wr_fire)
      bvalid <= 1'b1;
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      bresp <= `RESP_OKAY;
    else if (wr_fire)
      bresp <= wr_resp;
  end

  // all fields sit in byte lane 0, other lanes carry nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `CTRL_RESET;
    else if (ctrl_we)
      ctrl <= wr_data[3:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      preset <= `PRESET_RESET;
    else if (preset_we)
      preset <= wr_data[3:0];
  end

  // software step: one counting edge, taken the cycle after the write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sw_step <= 1'b0;
    else
      sw_step <= step_we && wr_data[`STEP_BIT];
  end

  // pin is already synchronous, so a single delay finds its rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_clock_q <= 1'b0;
    else
      count_clock_q <= count_clock;
  end

  assign pin_rise = count_clock && !count_clock_q;
  assign ctl.step = pin_rise || sw_step;

  assign ctl.clear_n       = ctrl[`CTRL_CLEAR_BIT];
  assign ctl.load_enable_n = ctrl[`CTRL_LOAD_BIT];
  assign ctl.preset        = preset;

  assign ctl.parallel_count_enable = ctrl[`CTRL_PCE_BIT]
                                   & cascade_parallel_enable;
  assign ctl.trickle_count_enable  = ctrl[`CTRL_TCE_BIT]
                                   & cascade_trickle_enable;

  bcd_core
  #(
    .ASYNC_CLEAR (ASYNC_CLEAR)
  )
  u_core
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl.core)
  );

  assign count_out          = ctl.count;
  // decoding glitches possible downstream; never clock or reset from it
  assign terminal_count_out = ctl.terminal_count_out;

  // read channel
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;

  assign rd_word       = {araddr[4:2], 2'b00};
  assign rd_ctrl_sel   = (rd_word == `CTRL_OFFSET);
  assign rd_preset_sel = (rd_word == `PRESET_OFFSET);
  assign rd_status_sel = (rd_word == `STATUS_OFFSET);
  assign rd_step_sel   = (rd_word == `STEP_OFFSET);
  assign rd_mapped     = rd_ctrl_sel | rd_preset_sel
                       | rd_status_sel | rd_step_sel;
  assign rd_resp       = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;

  assign ctrl_word   = {28'h000_0000, ctrl};
  assign preset_word = {28'h000_0000, preset};

  assign status_word = {24'h00_0000,
                        ctl.mode,
                        ASYNC_CLEAR,
                        ctl.terminal_count_out,
                        ctl.count};

  // step reads zero: it only launches an edge
  assign rd_value = rd_ctrl_sel   ? ctrl_word              :
                    rd_preset_sel ? preset_word            :
                    rd_status_sel ? status_word            :
                                    32'h0000_0000;

  // read answer stands until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rvalid <= 1'b0;
    else if (rd_fire)
      rvalid <= 1'b1;
    else if (rready)
      rvalid <= 1'b0;
  end

  // data captured at the take edge, so a later count does not tear it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata <= 32'h0000_0000;
    else if (rd_fire)
      rdata <= rd_value;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rresp <= `RESP_OKAY;
    else if (rd_fire)
      rresp <= rd_resp;
  end

endmodule

// file: bcd_decade_counter_props.sv
// Purpose: port-level relations of the decade counter
// Assumes: one clock, aclk; synchronous active-low reset
// Notes:   bound to every counter instance
`include "bcd_counter_params.svh"

module bcd_decade_counter_props
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic [1:0] bresp,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       count_clock,
  input wire logic       cascade_trickle_enable,
  input wire logic [3:0] count_out,
  input wire logic       terminal_count_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_TC_STATE9:
    assert property (terminal_count_out |-> count_out == 4'h9)
      else $error("terminal count outside state nine");
  AST_TC_TRICKLE:
    assert property (terminal_count_out |-> cascade_trickle_enable)
      else $error("terminal count without trickle enable");
  // a write may clear at once or step; otherwise only a pin rise
  AST_EDGE_ONLY:
    assert property ($changed(count_out) |-> bvalid || $past(bvalid)
      || ($past(count_clock) && !$past(count_clock, 2)))
      else $error("count moved without a counting edge");
  AST_B_AFTER_WRITE:
    assert property (awvalid && awready && wvalid && wready |=> bvalid)
      else $error("write response late");
  AST_B_HOLD:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
  AST_B_DONE:
    assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write channels not free after response");
  AST_R_AFTER_READ:
    assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
  AST_R_HOLD:
    assert property (rvalid && !rready |=> rvalid && !arready)
      else $error("read data dropped early");

  cover property (terminal_count_out);
  cover property (bvalid && bresp == `RESP_SLVERR);
  cover property ($past(count_out) == 4'h9 && count_out == 4'h0);
endmodule

bind bcd_decade_counter bcd_decade_counter_props i_props
(
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .count_clock,
  .cascade_trickle_enable, .count_out, .terminal_count_out
);

// file: bcd_decade_counter_tb_top.sv
// Purpose: directed bus tests of the decade counter
// Assumes: a sync-clear twin shares every input with i_dut
// Notes:   the twin is judged by its count alone
`include "bcd_counter_params.svh"

module bcd_decade_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0, aresetn = 1'b0, run = 1'b0, cascade = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, tri_force = 1'b1;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  wire         awready, wready, bvalid, arready, rvalid, count_clock;
  wire         cascade_parallel_enable, cascade_trickle_enable;
  wire         terminal_count_out;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  count_out, sync_count;
  int          fail_count = 0, n_compared = 0;

  always #4 aclk = ~aclk;

  bcd_decade_counter #(.ASYNC_CLEAR(1'b1)) i_dut
  (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .count_clock, .cascade_parallel_enable,
    .cascade_trickle_enable, .count_out, .terminal_count_out
  );
  bcd_decade_counter #(.ASYNC_CLEAR(1'b0)) i_sync
  (
    .aclk, .aresetn, .awvalid, .awready(), .awaddr, .wvalid, .wready(),
    .wdata, .wstrb, .bvalid(), .bready, .bresp(), .arvalid, .arready(),
    .araddr, .rvalid(), .rready, .rdata(), .rresp(), .count_clock,
    .cascade_parallel_enable, .cascade_trickle_enable,
    .count_out(sync_count), .terminal_count_out()
  );
  lower_stage_model i_lower
  (
    .aclk, .aresetn, .run, .cascade, .par_force(1'b1), .tri_force,
    .count_clock, .cascade_parallel_enable, .cascade_trickle_enable
  );

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready rises a cycle after valid so the hold case is exercised
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      bready <= bvalid && !bready;
    end
    while (!(bvalid && bready));
    chk("bresp", 32'(bresp), 32'(r));
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] r = `RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      rready <= rvalid && !rready;
    end
    while (!(rvalid && rready));
    chk("rdata", rdata, d);
    chk("rresp", 32'(rresp), 32'(r));
  endtask

  task automatic step;
    wr(`STEP_OFFSET, 32'h1);
  endtask

  function automatic logic [31:0] st(logic [1:0] m, logic tc, logic [3:0] c);
    return {24'h0, m, 1'b1, tc, c};
  endfunction

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CTRL_OFFSET, 32'h3);
    rd(`PRESET_OFFSET, 32'h0);
    rd(`STATUS_OFFSET, st(2'b11, 1'b0, 4'h0));
    rd(5'h10, 32'h0, `RESP_SLVERR);
    wr(5'h14, 32'hf, `RESP_SLVERR);
    wr(`STATUS_OFFSET, 32'h0);
    wr(`CTRL_OFFSET, 32'hf);
    for (int i = 1; i <= 12; i++)
    begin
      step();
      rd(`STATUS_OFFSET, st(2'b10, i % 10 == 9, 4'(i % 10)));
    end
    wr(`PRESET_OFFSET, 32'h9);
    wr(`CTRL_OFFSET, 32'h5);
    step();
    rd(`STATUS_OFFSET, st(2'b01, 1'b0, 4'h9));
    wr(`CTRL_OFFSET, 32'hb);
    step();
    rd(`STATUS_OFFSET, st(2'b11, 1'b1, 4'h9));
    tri_force <= 1'b0;
    wr(`CTRL_OFFSET, 32'hf);
    step();
    rd(`STATUS_OFFSET, st(2'b11, 1'b0, 4'h9));
    tri_force <= 1'b1;
    wr(`CTRL_OFFSET, 32'h0, `RESP_OKAY, 4'he);
    rd(`CTRL_OFFSET, 32'hf);
    for (int p = 10; p < 16; p++)
    begin
      wr(`PRESET_OFFSET, 32'(p));
      wr(`CTRL_OFFSET, 32'hd);
      step();
      chk("count", 32'(count_out), 32'(p));
      chk("tc", 32'(terminal_count_out), 32'h0);
      wr(`CTRL_OFFSET, 32'hf);
      repeat (2) step();
      chk("legal", 32'(count_out < 4'ha), 32'h1);
    end
    wr(`PRESET_OFFSET, 32'h5);
    wr(`CTRL_OFFSET, 32'hd);
    step();
    wr(`CTRL_OFFSET, 32'hc);
    chk("async", 32'(count_out), 32'h0);
    chk("sync", 32'(sync_count), 32'h5);
    rd(`STATUS_OFFSET, st(2'b00, 1'b0, 4'h0));
    step();
    chk("sync", 32'(sync_count), 32'h0);
    wr(`CTRL_OFFSET, 32'hf);
    cascade <= 1'b1;
    run     <= 1'b1;
    repeat (40) @(posedge aclk);
    run <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("cascade", 32'(count_out), 32'h2);
    chk("cascade", 32'(sync_count), 32'h2);
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    close_out();
  end
endmodule

// file: count_if.sv
// Purpose: control and result signals between bus front end and core
// Assumes: one clock, aclk
// Notes:   step is a one-cycle pulse standing for a counting clock edge
interface count_if;

  logic                   step;
  logic                   clear_n;
  logic                   load_enable_n;
  logic                   parallel_count_enable;
  logic                   trickle_count_enable;
  bcd_counter_pkg::bcd_t  preset;
  bcd_counter_pkg::bcd_t  count;
  logic                   terminal_count_out;
  bcd_counter_pkg::mode_t mode;

  modport control
  (
    output step,
    output clear_n,
    output load_enable_n,
    output parallel_count_enable,
    output trickle_count_enable,
    output preset,
    input  count,
    input  terminal_count_out,
    input  mode
  );

  modport core
  (
    input  step,
    input  clear_n,
    input  load_enable_n,
    input  parallel_count_enable,
    input  trickle_count_enable,
    input  preset,
    output count,
    output terminal_count_out,
    output mode
  );

endinterface

// file: lower_stage_model.sv
// Purpose: lower decade stage sharing the counting pin
// Assumes: pin toggles once per aclk cycle while run is high
// Notes:   pin rests low between bursts
module lower_stage_model
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic cascade,
  input  wire logic par_force,
  input  wire logic tri_force,
  output logic      count_clock,
  output wire logic cascade_parallel_enable,
  output wire logic cascade_trickle_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       prev_clock;
  logic [3:0] digit;
  wire        digit_nine = digit == 4'h9;

  initial count_clock = 1'b0;
  assign cascade_parallel_enable = cascade ? digit_nine : par_force;
  assign cascade_trickle_enable  = cascade ? digit_nine : tri_force;

  always @(posedge aclk)
  begin
    prev_clock  <= count_clock;
    count_clock <= aresetn && run && !count_clock;
    if (!aresetn)
      digit <= 4'h0;
    else if (count_clock && !prev_clock)
      digit <= digit_nine ? 4'h0 : digit + 4'h1;
  end
endmodule
